// >>> sau_defines.svh
// Constants shared by the scalar arithmetic units
`ifndef SAU_DEFINES_SVH
`define SAU_DEFINES_SVH

// ----------------------------------------
// Opcodes (octal 060..070)
// ----------------------------------------
`define SAU_OP_W 7
`define SAU_OP_IADD 7'h30
`define SAU_OP_ISUB 7'h31
`define SAU_OP_FADD 7'h32
`define SAU_OP_FSUB 7'h33
`define SAU_OP_FMUL 7'h34
`define SAU_OP_HMUL 7'h35
`define SAU_OP_RMUL 7'h36
`define SAU_OP_RITER 7'h37
`define SAU_OP_RECIP 7'h38

// ----------------------------------------
// Floating-point word layout
// ----------------------------------------
`define SAU_SIGN_BIT 63
`define SAU_EXP_HI 62
`define SAU_EXP_LO 48
`define SAU_COEF_HI 47
`define SAU_EXP_BIAS 16'h4000
`define SAU_EXP_BIAS2 16'h8000
`define SAU_SIGN_ONLY 64'h8000_0000_0000_0000
`define SAU_FP_TWO 64'h4002_8000_0000_0000
`define SAU_RECIP_NUM 96'h8000_0000_0000_0000_0000_0000
`define SAU_ALIGN_MAX 16'h0030
`define SAU_HALF_RND 49'h0_0000_0004_0000
`define SAU_HALF_CLR 49'h0_0000_0007_FFFF
`define SAU_RECIP_MASK 48'hFFFF_FFFC_0000

// ----------------------------------------
// Timing, in clock periods
// ----------------------------------------
`define SAU_PERIOD_CYCLES 1
`define SAU_ADD_READY_PERIODS 3
`define SAU_FADD_READY_PERIODS 6
`define SAU_FMUL_READY_PERIODS 7
`define SAU_RECIP_READY_PERIODS 14
`define SAU_VEC_EXTRA_PERIODS 4
`define SAU_VL_W 7
`define SAU_VCNT_W 8

`endif

// >>> sau_pkg.sv
// Types of the scalar arithmetic units
package sau_pkg;
	typedef enum logic [2:0] {
		SAU_U_NONE = 3'b000,
		SAU_U_ADD = 3'b001,
		SAU_U_FADD = 3'b010,
		SAU_U_FMUL = 3'b011,
		SAU_U_RECIP = 3'b100
	} sau_unit_t;

	typedef enum logic [1:0] {
		SAU_MUL_FULL = 2'b00,
		SAU_MUL_HALF = 2'b01,
		SAU_MUL_ROUND = 2'b10
	} sau_mul_mode_t;
endpackage

// >>> sau_pipe.sv
// Fixed-latency result pipeline carrying valid, destination and data
`timescale 1ns/10ps
module sau_pipe #(
	parameter int LAT = 3,
	parameter int DW = 64
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic in_vld,
	input wire logic [2:0] in_dest,
	input wire logic [DW-1:0] in_data,
	output logic out_vld,
	output logic [2:0] out_dest,
	output logic [DW-1:0] out_data
);
	logic vld_ff [LAT];
	logic [2:0] dest_ff [LAT];
	logic [DW-1:0] data_ff [LAT];

	// ----------------------------------------
	// Stages
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < LAT; g++) begin : stg
			logic nxt_vld;
			logic [2:0] nxt_dest;
			logic [DW-1:0] nxt_data;
			if (g == 0) begin : first
				assign nxt_vld = in_vld;
				assign nxt_dest = in_dest;
				assign nxt_data = in_data;
			end else begin : rest
				assign nxt_vld = vld_ff[g-1];
				assign nxt_dest = dest_ff[g-1];
				assign nxt_data = data_ff[g-1];
			end
			always_ff @(posedge ref_clk) begin
				if (!nrst) begin
					vld_ff[g] <= 1'b0;
					dest_ff[g] <= 3'h0;
					data_ff[g] <= '0;
				end else begin
					vld_ff[g] <= nxt_vld;
					dest_ff[g] <= nxt_dest;
					data_ff[g] <= nxt_data;
				end
			end
		end
	endgenerate

	assign out_vld = vld_ff[LAT-1];
	assign out_dest = dest_ff[LAT-1];
	assign out_data = data_ff[LAT-1];
endmodule

// >>> sau_top.sv
// Scalar integer add, floating add, floating multiply and reciprocal units
// ----------------------------------------
// Overview of operation
// - Integer add: 64-bit sum, no overflow
// - Integer subtract: first minus second, no overflow
// - Integer add result ready three periods
// - Hold issue on busy, exchange, conflict, reservation
// - Floating add result always normalized
// - Floating add writes normalized sum
// - Floating subtract writes normalized difference
// - Subtract with zero first field: negate second, normalized
// - Hold floating add while vector add busy
// - Floating add result ready six periods
// - Multiply result may stay unnormalized
// - Full multiply writes floating product
// - Half multiply rounds, clears nineteen bits
// - Rounded multiply writes rounded product
// - Reciprocal iteration writes two minus product
// - Hold multiply while vector multiply busy
// - Multiply result ready seven periods
// - Zero exponents select integer multiply
// - Integer multiply keeps upper 48 product bits
// - Reciprocal estimate accurate to 30 bits
// - Reciprocal ready fourteen, held by vector use
// ----------------------------------------
`timescale 1ns/10ps
`include "sau_defines.svh"
module sau_top
	import sau_pkg::*;
#(
	parameter int ADD_LAT = `SAU_ADD_READY_PERIODS * `SAU_PERIOD_CYCLES,
	parameter int FADD_LAT = `SAU_FADD_READY_PERIODS * `SAU_PERIOD_CYCLES,
	parameter int FMUL_LAT = `SAU_FMUL_READY_PERIODS * `SAU_PERIOD_CYCLES,
	parameter int RECIP_LAT = `SAU_RECIP_READY_PERIODS * `SAU_PERIOD_CYCLES
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic issue_req,
	input wire logic [`SAU_OP_W-1:0] issue_op,
	input wire logic [2:0] issue_i,
	input wire logic [2:0] issue_j,
	input wire logic [2:0] issue_k,
	input wire logic [63:0] first_src_scalar_reg,
	input wire logic [63:0] second_src_scalar_reg,
	input wire logic blk_034_busy,
	input wire logic exch_busy,
	input wire logic sreg_conflict,
	input wire logic [7:0] s_reserved,
	input wire logic vec_fadd_start,
	input wire logic vec_fmul_start,
	input wire logic vec_recip_start,
	input wire logic [`SAU_VL_W-1:0] vector_length_reg,
	output logic issue_hold,
	output logic issue_taken,
	output logic add_wb_vld,
	output logic [2:0] add_wb_dest,
	output logic [63:0] add_wb_data,
	output logic fadd_wb_vld,
	output logic [2:0] fadd_wb_dest,
	output logic [63:0] fadd_wb_data,
	output logic fmul_wb_vld,
	output logic [2:0] fmul_wb_dest,
	output logic [63:0] fmul_wb_data,
	output logic recip_wb_vld,
	output logic [2:0] recip_wb_dest,
	output logic [63:0] recip_wb_data
);
	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic sau_unit_t sau_decode(input logic [`SAU_OP_W-1:0] op);
		sau_unit_t u;
		u = SAU_U_NONE;
		if (op == `SAU_OP_IADD || op == `SAU_OP_ISUB) begin
			u = SAU_U_ADD;
		end else if (op == `SAU_OP_FADD || op == `SAU_OP_FSUB) begin
			u = SAU_U_FADD;
		end else if (op >= `SAU_OP_FMUL && op <= `SAU_OP_RITER) begin
			u = SAU_U_FMUL;
		end else if (op == `SAU_OP_RECIP) begin
			u = SAU_U_RECIP;
		end
		return u;
	endfunction

	function automatic logic sau_rsv(input logic [7:0] rsv, input logic [2:0] idx);
		return rsv[idx];
	endfunction

	function automatic logic [5:0] sau_lzc(input logic [47:0] m);
		logic [5:0] n;
		n = 6'h00;
		for (int b = 0; b < 48; b++) begin
			if (m[b]) begin
				n = 6'(47 - b);
			end
		end
		return n;
	endfunction

	// Magnitudes are ordered on exponent then coefficient; an unnormalized
	// operand with the larger exponent can still hold the smaller
	// coefficient, so a negative difference is flipped along with the sign.
	function automatic logic [63:0] sau_fadd(input logic [63:0] a, input logic [63:0] b);
		logic swap;
		logic flip;
		logic [63:0] big;
		logic [63:0] sml;
		logic [15:0] diff;
		logic [47:0] al;
		logic [48:0] sum;
		logic [5:0] lz;
		logic [15:0] er;
		logic [47:0] mr;
		logic [63:0] res;
		swap = a[`SAU_EXP_HI:0] < b[`SAU_EXP_HI:0];
		big = swap ? b : a;
		sml = swap ? a : b;
		diff = 16'(big[`SAU_EXP_HI:`SAU_EXP_LO]) - 16'(sml[`SAU_EXP_HI:`SAU_EXP_LO]);
		al = (diff > `SAU_ALIGN_MAX) ? 48'h0 : sml[`SAU_COEF_HI:0] >> diff;
		flip = 1'b0;
		if (big[`SAU_SIGN_BIT] == sml[`SAU_SIGN_BIT]) begin
			sum = {1'b0, big[`SAU_COEF_HI:0]} + {1'b0, al};
		end else if (big[`SAU_COEF_HI:0] < al) begin
			sum = {1'b0, al} - {1'b0, big[`SAU_COEF_HI:0]};
			flip = 1'b1;
		end else begin
			sum = {1'b0, big[`SAU_COEF_HI:0]} - {1'b0, al};
		end
		er = 16'(big[`SAU_EXP_HI:`SAU_EXP_LO]);
		lz = sau_lzc(sum[47:0]);
		if (sum[48]) begin
			mr = sum[48:1];
			er = er + 16'h0001;
		end else begin
			mr = sum[47:0] << lz;
			er = er - 16'(lz);
		end
		res = {big[`SAU_SIGN_BIT] ^ flip, er[14:0], mr};
		if (sum == 49'h0) begin
			res = 64'h0;
		end
		return res;
	endfunction

	function automatic logic [63:0] sau_fmul(input logic [63:0] a, input logic [63:0] b,
		input sau_mul_mode_t mode);
		logic [95:0] p;
		logic nrm;
		logic [48:0] m;
		logic rb;
		logic [15:0] e;
		logic [63:0] res;
		p = 96'(a[`SAU_COEF_HI:0]) * 96'(b[`SAU_COEF_HI:0]);
		nrm = p[95];
		m = nrm ? {1'b0, p[95:48]} : {1'b0, p[94:47]};
		rb = nrm ? p[47] : p[46];
		e = 16'(a[`SAU_EXP_HI:`SAU_EXP_LO]) + 16'(b[`SAU_EXP_HI:`SAU_EXP_LO]) - `SAU_EXP_BIAS;
		if (!nrm) begin
			e = e - 16'h0001;
		end
		unique case (mode)
			SAU_MUL_ROUND: m = m + {48'h0, rb};
			SAU_MUL_HALF: m = m + `SAU_HALF_RND;
			SAU_MUL_FULL: m = m;
			default: m = m;
		endcase
		if (m[48]) begin
			m = m >> 1;
			e = e + 16'h0001;
		end
		if (mode == SAU_MUL_HALF) begin
			m = m & ~`SAU_HALF_CLR;
		end
		// No post-normalize: unnormalized inputs give unnormalized products
		res = {a[`SAU_SIGN_BIT] ^ b[`SAU_SIGN_BIT], e[14:0], m[47:0]};
		// Both exponents zero: the integer product replaces the float
		if (a[`SAU_EXP_HI:`SAU_EXP_LO] == 15'h0 && b[`SAU_EXP_HI:`SAU_EXP_LO] == 15'h0) begin
			res = {16'h0, p[95:48]};
		end
		return res;
	endfunction

	// Exact division then truncation to the guaranteed precision; a
	// cheaper seed table would meet the same accuracy at lower area.
	function automatic logic [63:0] sau_recip(input logic [63:0] a);
		logic [95:0] q;
		logic [15:0] e;
		logic [47:0] m;
		// A zero divisor has no meaning; all ones keeps the data known
		if (a[`SAU_COEF_HI:0] == 48'h0) begin
			q = '1;
		end else begin
			q = `SAU_RECIP_NUM / 96'(a[`SAU_COEF_HI:0]);
		end
		e = `SAU_EXP_BIAS2 - 16'(a[`SAU_EXP_HI:`SAU_EXP_LO]) + 16'h0001;
		m = q[47:0];
		if (q[48]) begin
			m = q[48:1];
			e = e + 16'h0001;
		end
		return {a[`SAU_SIGN_BIT], e[14:0], m & `SAU_RECIP_MASK};
	endfunction

	// ----------------------------------------
	// Operand selection
	// ----------------------------------------
	wire logic j_zero = issue_j == 3'h0;
	wire logic k_zero = issue_k == 3'h0;
	wire logic is_isub = issue_op == `SAU_OP_ISUB;
	wire logic is_fsub = issue_op == `SAU_OP_FSUB;
	wire logic is_hmul = issue_op == `SAU_OP_HMUL;
	wire logic is_rmul = issue_op == `SAU_OP_RMUL;
	wire logic is_riter = issue_op == `SAU_OP_RITER;

	wire logic [63:0] opa = j_zero ? 64'h0 : first_src_scalar_reg;
	wire logic [63:0] opb = k_zero ? `SAU_SIGN_ONLY : second_src_scalar_reg;
	wire logic [63:0] opb_neg = opb ^ `SAU_SIGN_ONLY;
	wire sau_unit_t unit = sau_decode(issue_op);

	// ----------------------------------------
	// Vector-shared unit busy counters
	// ----------------------------------------
	// Busy spans the start cycle plus length+3 counted cycles, length+4 in all;
	// eight count bits hold the longest length with the extra periods
	logic [2:0] vstart;
	logic [2:0] vbusy;
	assign vstart = {vec_recip_start, vec_fmul_start, vec_fadd_start};

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : vcnt
			logic [`SAU_VCNT_W-1:0] cnt_ff;
			logic [`SAU_VCNT_W-1:0] nxt_cnt;
			assign nxt_cnt = vstart[g] ?
				`SAU_VCNT_W'(vector_length_reg) + `SAU_VCNT_W'(`SAU_VEC_EXTRA_PERIODS - 1) :
				(cnt_ff != '0) ? cnt_ff - `SAU_VCNT_W'(1) : cnt_ff;
			assign vbusy[g] = vstart[g] | (cnt_ff != '0);
			always_ff @(posedge ref_clk) begin
				if (!nrst) begin
					cnt_ff <= '0;
				end else begin
					cnt_ff <= nxt_cnt;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Issue hold
	// ----------------------------------------
	wire logic unit_busy = (unit == SAU_U_FADD && vbusy[0])
		|| (unit == SAU_U_FMUL && vbusy[1])
		|| (unit == SAU_U_RECIP && vbusy[2]);
	// The reciprocal reads only the first source, so k is not checked
	wire logic rsv_i = sau_rsv(s_reserved, issue_i);
	wire logic rsv_j = sau_rsv(s_reserved, issue_j);
	wire logic rsv_k = sau_rsv(s_reserved, issue_k);
	wire logic rsv_hit = rsv_i || rsv_j || (unit != SAU_U_RECIP && rsv_k);
	wire logic conflict = sreg_conflict && unit != SAU_U_RECIP;

	// Unknown opcodes belong to other units and are neither held nor taken
	assign issue_hold = issue_req && unit != SAU_U_NONE
		&& (blk_034_busy || exch_busy || conflict || rsv_hit || unit_busy);
	assign issue_taken = issue_req && unit != SAU_U_NONE && !issue_hold;

	// ----------------------------------------
	// Result formation
	// ----------------------------------------
	wire logic [63:0] add_res = is_isub ?
		opa - opb :
		opa + opb;

	wire logic [63:0] fsum = sau_fadd(opa, is_fsub ? opb_neg : opb);
	wire logic [63:0] fneg = sau_fadd(64'h0, opb_neg);
	// Zero operand keeps its sign flip only when the operand is nonzero
	wire logic [63:0] fadd_res = (is_fsub && j_zero) ?
		((opb == 64'h0) ? 64'h0 : fneg) :
		fsum;

	wire sau_mul_mode_t mmode = is_hmul ? SAU_MUL_HALF :
		is_rmul ? SAU_MUL_ROUND : SAU_MUL_FULL;
	wire logic [63:0] prod = sau_fmul(opa, opb, mmode);
	wire logic [63:0] riter = sau_fadd(`SAU_FP_TWO, prod ^ `SAU_SIGN_ONLY);
	wire logic [63:0] fmul_res = is_riter ? riter : prod;

	wire logic [63:0] recip_res = sau_recip(opa);

	// ----------------------------------------
	// Per-unit issue strobes
	// ----------------------------------------
	wire logic add_go = issue_taken && unit == SAU_U_ADD;
	wire logic fadd_go = issue_taken && unit == SAU_U_FADD;
	wire logic fmul_go = issue_taken && unit == SAU_U_FMUL;
	wire logic recip_go = issue_taken && unit == SAU_U_RECIP;

	// ----------------------------------------
	// Fixed-latency result pipelines
	// ----------------------------------------
	sau_pipe #(.LAT(ADD_LAT), .DW(64)) u_add_pipe (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.in_vld(add_go),
		.in_dest(issue_i),
		.in_data(add_res),
		.out_vld(add_wb_vld),
		.out_dest(add_wb_dest),
		.out_data(add_wb_data)
	);

	sau_pipe #(.LAT(FADD_LAT), .DW(64)) u_fadd_pipe (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.in_vld(fadd_go),
		.in_dest(issue_i),
		.in_data(fadd_res),
		.out_vld(fadd_wb_vld),
		.out_dest(fadd_wb_dest),
		.out_data(fadd_wb_data)
	);

	sau_pipe #(.LAT(FMUL_LAT), .DW(64)) u_fmul_pipe (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.in_vld(fmul_go),
		.in_dest(issue_i),
		.in_data(fmul_res),
		.out_vld(fmul_wb_vld),
		.out_dest(fmul_wb_dest),
		.out_data(fmul_wb_data)
	);

	sau_pipe #(.LAT(RECIP_LAT), .DW(64)) u_recip_pipe (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.in_vld(recip_go),
		.in_dest(issue_i),
		.in_data(recip_res),
		.out_vld(recip_wb_vld),
		.out_dest(recip_wb_dest),
		.out_data(recip_wb_data)
	);
endmodule

// >>> sau_top_assertions.sv
// Port-level timing, hold and data checks for the scalar arithmetic units
`timescale 1ns/10ps
`include "sau_defines.svh"
module sau_top_assertions #(
	parameter int ADD_LAT = 3,
	parameter int FADD_LAT = 6,
	parameter int FMUL_LAT = 7,
	parameter int RECIP_LAT = 14
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic issue_req,
	input wire logic [`SAU_OP_W-1:0] issue_op,
	input wire logic [2:0] issue_i,
	input wire logic blk_034_busy,
	input wire logic exch_busy,
	input wire logic vec_fmul_start,
	input wire logic issue_hold,
	input wire logic issue_taken,
	input wire logic add_wb_vld,
	input wire logic [2:0] add_wb_dest,
	input wire logic fadd_wb_vld,
	input wire logic [2:0] fadd_wb_dest,
	input wire logic fmul_wb_vld,
	input wire logic [2:0] fmul_wb_dest,
	input wire logic [63:0] fmul_wb_data,
	input wire logic recip_wb_vld,
	input wire logic [2:0] recip_wb_dest
);
	// ----
	// Sequences and checks
	// ----
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire known = issue_op >= `SAU_OP_IADD && issue_op <= `SAU_OP_RECIP;
	sequence take(lo, hi);
		issue_taken && issue_op >= lo && issue_op <= hi;
	endsequence
	sequence offer(lo, hi);
		issue_req && issue_op >= lo && issue_op <= hi;
	endsequence
	// Shortest vector length still keeps the unit busy three periods on
	sequence fmul_busy_s;
		vec_fmul_start ##3 offer(`SAU_OP_FMUL, `SAU_OP_RITER);
	endsequence
	chk_add_lat: assert property (take(`SAU_OP_IADD, `SAU_OP_ISUB) |-> ##ADD_LAT
		add_wb_vld && add_wb_dest == $past(issue_i, ADD_LAT)) else $error("add result off time");
	chk_fadd_lat: assert property (take(`SAU_OP_FADD, `SAU_OP_FSUB) |-> ##FADD_LAT
		fadd_wb_vld && fadd_wb_dest == $past(issue_i, FADD_LAT)) else $error("fadd result off time");
	chk_fmul_lat: assert property (take(`SAU_OP_FMUL, `SAU_OP_RITER) |-> ##FMUL_LAT
		fmul_wb_vld && fmul_wb_dest == $past(issue_i, FMUL_LAT)) else $error("fmul result off time");
	chk_recip_lat: assert property (take(`SAU_OP_RECIP, `SAU_OP_RECIP) |-> ##RECIP_LAT
		recip_wb_vld && recip_wb_dest == $past(issue_i, RECIP_LAT)) else $error("recip result off time");
	chk_hold_busy: assert property (issue_req && known && (blk_034_busy || exch_busy) |->
		issue_hold && !issue_taken) else $error("issued while busy");
	chk_vec_hold: assert property (fmul_busy_s |-> issue_hold) else $error("fmul not held");
	chk_half_clear: assert property (fmul_wb_vld && $past(issue_taken, FMUL_LAT) &&
		$past(issue_op, FMUL_LAT) == `SAU_OP_HMUL |-> fmul_wb_data[18:0] == 19'h0) else $error("half low bits");
	chk_unknown_op: assert property (issue_req && !known |-> !issue_hold && !issue_taken)
		else $error("unknown opcode acted on");
endmodule
bind sau_top sau_top_assertions #(.ADD_LAT(ADD_LAT), .FADD_LAT(FADD_LAT), .FMUL_LAT(FMUL_LAT), .RECIP_LAT(RECIP_LAT))
	sau_top_assertions_inst (.ref_clk, .nrst, .issue_req, .issue_op, .issue_i, .blk_034_busy, .exch_busy,
	.vec_fmul_start, .issue_hold, .issue_taken, .add_wb_vld, .add_wb_dest, .fadd_wb_vld, .fadd_wb_dest,
	.fmul_wb_vld, .fmul_wb_dest, .fmul_wb_data, .recip_wb_vld, .recip_wb_dest);

// >>> sau_sreg_model.sv
// Scalar register file model on the issuing side
`timescale 1ns/10ps
module sau_sreg_model (
	input wire logic ref_clk,
	input wire logic ld_en,
	input wire logic [2:0] ld_idx,
	input wire logic [63:0] ld_val,
	input wire logic [2:0] issue_j,
	input wire logic [2:0] issue_k,
	output logic [63:0] first_src_scalar_reg,
	output logic [63:0] second_src_scalar_reg
);
	logic [63:0] regs_ff [8];
	// Slot 0 churns, so reading it instead of the fixed operand shows
	always_ff @(posedge ref_clk) begin
		if (ld_en)
			regs_ff[ld_idx] <= ld_val;
		else
			regs_ff[0] <= {regs_ff[0][62:0], ~regs_ff[0][63]};
	end
	// Bench offers only short estimates to the iteration
	assign first_src_scalar_reg = regs_ff[issue_j];
	assign second_src_scalar_reg = regs_ff[issue_k];
endmodule

// >>> testbench.sv
// Self-checking bench for the scalar arithmetic units
`timescale 1ns/10ps
`include "sau_defines.svh"
module testbench;
	typedef struct {logic [6:0] op; logic [5:0] jk; logic [63:0] a, b, e;} sau_case_t;
	localparam logic [63:0] one = 64'h4001_8000_0000_0000;
	localparam logic [63:0] five = 64'h4003_A000_0000_0000;
	logic ref_clk = 0, nrst = 0, issue_req = 0, blk_034_busy = 0, exch_busy = 0, sreg_conflict = 0, ld_en = 0, vh = 0;
	logic vec_fadd_start = 0, vec_fmul_start = 0, vec_recip_start = 0;
	logic [6:0] issue_op = 0, vector_length_reg = 0;
	logic [2:0] issue_i = 0, issue_j = 0, issue_k = 0, ld_idx = 0;
	logic [7:0] s_reserved = 0;
	logic [63:0] ld_val = 0, first_src_scalar_reg, second_src_scalar_reg, a, b, sh [8];
	logic issue_hold, issue_taken, add_wb_vld, fadd_wb_vld, fmul_wb_vld, recip_wb_vld;
	logic [2:0] add_wb_dest, fadd_wb_dest, fmul_wb_dest, recip_wb_dest;
	logic [63:0] add_wb_data, fadd_wb_data, fmul_wb_data, recip_wb_data;
	logic [66:0] wd [4];
	logic [130:0] exq [4][$];
	logic [31:0] rng = 32'hC2A49BC8;
	int bad_count = 0, n_checks = 0, cyc = 0, w;
	sau_case_t tbl [13] = '{'{7'h32, 6'o12, one, one, `SAU_FP_TWO}, '{7'h33, 6'o12, `SAU_FP_TWO, one, one},
		'{7'h32, 6'o02, 0, 64'h4002_4000_0000_0000, one}, '{7'h33, 6'o02, 0, one, 64'hC001_8000_0000_0000},
		'{7'h33, 6'o02, 0, 0, 0}, '{7'h34, 6'o12, one, five, five}, '{7'h36, 6'o12, one, five, five},
		'{7'h35, 6'o12, one, 64'h4001_C000_0004_FFFF, 64'h4001_C000_0008_0000}, '{7'h37, 6'o12, one, one, one},
		'{7'h34, 6'o12, 64'h300_0000, 64'h500_0000, 64'hF}, '{7'h38, 6'o12, 64'h4003_8000_0000_0000,
		0, 64'h3FFF_8000_0000_0000}, '{7'h30, 6'o00, 0, 0, `SAU_SIGN_ONLY}, '{7'h31, 6'o10, 5, 0, 64'h8000_0000_0000_0005}};
	wire [3:0] wv = {recip_wb_vld, fmul_wb_vld, fadd_wb_vld, add_wb_vld};
	assign wd[0] = {add_wb_dest, add_wb_data};
	assign wd[1] = {fadd_wb_dest, fadd_wb_data};
	assign wd[2] = {fmul_wb_dest, fmul_wb_data};
	assign wd[3] = {recip_wb_dest, recip_wb_data};
	sau_top sau_top_inst (.ref_clk, .nrst, .issue_req, .issue_op, .issue_i, .issue_j, .issue_k,
		.first_src_scalar_reg, .second_src_scalar_reg, .blk_034_busy, .exch_busy, .sreg_conflict, .s_reserved,
		.vec_fadd_start, .vec_fmul_start, .vec_recip_start, .vector_length_reg, .issue_hold, .issue_taken,
		.add_wb_vld, .add_wb_dest, .add_wb_data, .fadd_wb_vld, .fadd_wb_dest, .fadd_wb_data, .fmul_wb_vld,
		.fmul_wb_dest, .fmul_wb_data, .recip_wb_vld, .recip_wb_dest, .recip_wb_data);
	sau_sreg_model sau_sreg_model_inst (.ref_clk, .ld_en, .ld_idx, .ld_val, .issue_j, .issue_k,
		.first_src_scalar_reg, .second_src_scalar_reg);
	always #12.5 ref_clk = ~ref_clk;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	task automatic check(input logic [66:0] got, input logic [66:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic load(input logic [2:0] idx, input logic [63:0] v);
		ld_en = 1;
		ld_idx = idx;
		ld_val = v;
		sh[idx] = v;
		@(posedge ref_clk);
		#1;
	endtask
	// Leaves the request up so the next call issues back to back
	task automatic issue(input logic [6:0] op, input logic [2:0] i, j, k, input logic [63:0] m, ev);
		issue_req = 1;
		issue_op = op;
		issue_i = i;
		issue_j = j;
		issue_k = k;
		w = 0;
		@(negedge ref_clk);
		check(67'(issue_hold), 67'(vh | blk_034_busy | exch_busy | s_reserved[i] | s_reserved[j]
			| (op != 7'h38 && (sreg_conflict | s_reserved[k]))));
		while (issue_taken !== 1'b1 && w < 60) begin
			@(posedge ref_clk);
			#1 {blk_034_busy, exch_busy, sreg_conflict, vec_fadd_start, vec_fmul_start, vec_recip_start} = 6'h0;
			s_reserved = 8'h0;
			w++;
			@(negedge ref_clk);
		end
		exq[op < 7'h32 ? 0 : op < 7'h34 ? 1 : op < 7'h38 ? 2 : 3].push_back({m, i, ev});
		@(posedge ref_clk);
		#1;
	endtask
	always @(negedge ref_clk) begin
		logic [130:0] e;
		for (int u = 0; u < 4; u++) begin
			if (wv[u] === 1'b1) begin
				e = exq[u].size() > 0 ? exq[u].pop_front() : '1;
				check({wd[u][66:64], wd[u][63:0] & e[130:67]}, {e[66:64], e[63:0] & e[130:67]});
			end
		end
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial begin
		for (int r = 0; r < 6; r++) begin
			rng = xs(rng);
			load(3'(r), {rng, rng ^ 32'h9E37_79B9});
		end
		load(3'h6, 64'h7FFF_FFFF_FFFF_FFFF);
		load(3'h7, 64'hFFFF_FFFF_FFFF_FFFF);
		ld_en = 0;
		repeat (4) @(posedge ref_clk);
		#1 nrst = 1;
		for (int n = 0; n < 60; n++) begin
			rng = xs(rng);
			if (rng[11:10] == 2'h0) begin
				{blk_034_busy, exch_busy, sreg_conflict} = rng[15:13];
				s_reserved = {rng[23:17], 1'b0};
			end
			a = rng[6:4] != 0 ? sh[rng[6:4]] : 64'h0;
			b = rng[9:7] != 0 ? sh[rng[9:7]] : `SAU_SIGN_ONLY;
			issue(7'h30 | 7'(rng[0]), rng[3:1], rng[6:4], rng[9:7], '1, rng[0] ? a - b : a + b);
		end
		$display("random add stream done");
		foreach (tbl[c]) begin
			issue_req = 0;
			load(3'h1, tbl[c].a);
			load(3'h2, tbl[c].b);
			ld_en = 0;
			issue(tbl[c].op, 3'h3, tbl[c].jk[5:3], tbl[c].jk[2:0], tbl[c].op == 7'h38 ? 64'hFFFF_FFFF_FFFC_0000 : '1, tbl[c].e);
		end
		$display("directed operations done");
		for (int u = 0; u < 3; u++) begin
			{vec_fadd_start, vec_fmul_start, vec_recip_start} = 3'h1 << u;
			vector_length_reg = 7'(2 + u);
			vh = 1;
			issue(u == 0 ? 7'h38 : u == 1 ? 7'h34 : 7'h32, 3'h4, 3'h1, 3'h2, '0, '0);
			vh = 0;
			check(67'(w), 67'(6 + u));
		end
		$display("vector hold done");
		blk_034_busy = 1;
		issue_op = 7'h39;
		@(negedge ref_clk);
		check(67'({issue_hold, issue_taken}), 67'h0);
		@(posedge ref_clk);
		#1 blk_034_busy = 0;
		issue_req = 0;
		repeat (20) @(posedge ref_clk);
		$display("unknown opcode done");
		tally_and_finish();
	end
endmodule
